// File: core/ecsw_cnt.v
// Purpose: One 8-bit compare-match counter channel.
// Assumes: tick is a one-cycle count pulse on pclk.
// Notes:   Stopped counters hold zero; match is a one-cycle pulse.
module ecsw_cnt
(
    input  wire       pclk,
    input  wire       presetn,
    input  wire       pclk_en,
    input  wire       run,
    input  wire       tick,
    input  wire [7:0] cmp,
    output wire [7:0] value,
    output wire       match
);
    reg [7:0] value_r;
    reg [7:0] value_nxt;
    reg       match_r;
    reg       match_nxt;

    // Next count: clear when stopped, wrap to zero on a compare match.
    always @*
    begin
        value_nxt = value_r;
        match_nxt = 1'b0;
        if (!run)
            value_nxt = 8'h00;
        else if (tick)
        begin
            if (value_r == cmp)
            begin
                value_nxt = 8'h00;
                match_nxt = 1'b1;
            end
            else
                value_nxt = value_r + 8'h01;
        end
    end

    // Count and match registers.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            value_r <= 8'h00;
            match_r <= 1'b0;
        end
        else if (pclk_en)
        begin
            value_r <= value_nxt;
            match_r <= match_nxt;
        end
    end

    assign value = value_r;
    assign match = match_r & pclk_en;
endmodule

// File: core/ecsw_map.vh
// Purpose: Register offsets, field positions, reset values and divider
//          exponents of the event counter and square wave timer.
// Assumes: APB byte addresses on an 8-bit paddr; one aligned word each.
// Notes:   Definitions only; included by its bare name.
`ifndef ECSW_MAP_VH
`define ECSW_MAP_VH

// Register byte offsets.
`define ECSW_OFS_MODE0      8'h00
`define ECSW_OFS_MODE1      8'h04
`define ECSW_OFS_MODE2      8'h08
`define ECSW_OFS_CMP0       8'h0C
`define ECSW_OFS_CMP1       8'h10
`define ECSW_OFS_CMP2       8'h14
`define ECSW_OFS_CNT0       8'h18
`define ECSW_OFS_CNT1       8'h1C
`define ECSW_OFS_CNT2       8'h20
`define ECSW_OFS_PORT       8'h24
`define ECSW_OFS_IRQ_STAT   8'h28
`define ECSW_OFS_IRQ_CLR    8'h2C
`define ECSW_OFS_IRQ_EN     8'h30
`define ECSW_OFS_PIN_STAT   8'h34

// Mode register fields.
`define ECSW_BIT_RUN        7
`define ECSW_BIT_SRC_HI     2
`define ECSW_BIT_SRC_LO     1
`define ECSW_BIT_WAVE_OE    0
`define ECSW_MODE01_MASK    8'h86
`define ECSW_MODE2_MASK     8'h87
`define ECSW_MODE_RST       8'h00

// Port register fields: bit 0 direction (1 = input), bit 1 output latch.
`define ECSW_BIT_PORT_DIR   0
`define ECSW_BIT_PORT_LAT   1
`define ECSW_PORT_MASK      8'h03
`define ECSW_PORT_RST       8'h01

// Other reset values.
`define ECSW_CMP_RST        8'h00
`define ECSW_IRQ_RST        3'h0

// Prescaler width and divider exponents of the main clock per channel.
`define ECSW_PRE_W          9
`define ECSW_DIV0_A         4'h6
`define ECSW_DIV0_B         4'h9
`define ECSW_DIV1_A         4'h4
`define ECSW_DIV1_B         4'h8
`define ECSW_DIV2_A         4'h3
`define ECSW_DIV2_B         4'h7

`endif

// File: core/ecsw_sync.v
// Purpose: Three-stage synchroniser with single-count edge detection.
// Assumes: The input is asynchronous to pclk and slower than pclk/4.
// Notes:   A change is accepted once the second and third stages agree.
module ecsw_sync
(
    input  wire pclk,
    input  wire presetn,
    input  wire pclk_en,
    input  wire async_in,
    output wire level,
    output wire rise,
    output wire fall
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    reg stable_r;

    // Stage chain and the accepted level; s1 feeds only s2.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r     <= 1'b0;
            s2_r     <= 1'b0;
            s3_r     <= 1'b0;
            stable_r <= 1'b0;
        end
        else if (pclk_en)
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                stable_r <= s3_r;
        end
    end

    // Each accepted change yields one pulse, active while enabled.
    assign level = stable_r;
    assign rise  = pclk_en & (s2_r == s3_r) & s3_r & ~stable_r;
    assign fall  = pclk_en & (s2_r == s3_r) & ~s3_r & stable_r;
endmodule

// File: core/ecsw_top.v
// Purpose: Three 8-bit compare-match timers behind an APB slave; two count
//          external events, the third drives a square wave on a shared pin.
// Assumes: pclk is the main clock; sub_clk_in is the slow subsystem clock.
// Notes:   Zero-wait APB; unmapped addresses answer with pslverr.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "ecsw_map.vh"

module ecsw_top
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pclk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        event_input_zero,
    input  wire        event_input_one,
    input  wire        sub_clk_in,
    input  wire        wave_port_in,
    output wire        wave_port_out,
    output wire        wave_port_oe,
    output wire        match_irq_zero,
    output wire        match_irq_one,
    output wire        wave_match_irq,
    output wire        irq
);
    // Software-visible state.
    reg  [7:0]  mode_r [0:2];
    reg  [7:0]  cmp_r  [0:2];
    reg  [7:0]  port_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_stat_nxt;
    reg  [2:0]  irq_en_r;
    reg  [31:0] prdata_r;
    reg  [31:0] rd_data;
    reg         hit;

    // Timing and channel state.
    reg  [8:0]  pre_r;
    reg         wave_r;
    reg         wave_nxt;
    reg  [2:0]  tick;
    wire [2:0]  run_eff;
    wire [2:0]  match;
    wire [7:0]  value [0:2];

    // Synchronised pin levels and edges.
    wire        ev0_level;
    wire        ev0_rise;
    wire        ev0_fall;
    wire        ev1_level;
    wire        ev1_rise;
    wire        ev1_fall;
    wire        sub_rise;
    wire        wave_in_level;

    // Bus phases.
    wire        setup_ph;
    wire        wr_acc;
    wire        clr_wr;
    integer     k;

    // Returns one when the prescaler low bits selected by exp are all ones.
    function div_tick;
        input [8:0] pre;
        input [3:0] exp;
        reg   [8:0] msk;
        begin
            msk      = (9'h001 << exp) - 9'h001;
            div_tick = &(pre | ~msk);
        end
    endfunction

    // Event pins and the subsystem clock enter through synchronisers.
    ecsw_sync u_sync_ev0
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .pclk_en  (pclk_en),
        .async_in (event_input_zero),
        .level    (ev0_level),
        .rise     (ev0_rise),
        .fall     (ev0_fall)
    );

    ecsw_sync u_sync_ev1
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .pclk_en  (pclk_en),
        .async_in (event_input_one),
        .level    (ev1_level),
        .rise     (ev1_rise),
        .fall     (ev1_fall)
    );

    ecsw_sync u_sync_sub
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .pclk_en  (pclk_en),
        .async_in (sub_clk_in),
        .level    (),
        .rise     (sub_rise),
        .fall     ()
    );

    ecsw_sync u_sync_wave
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .pclk_en  (pclk_en),
        .async_in (wave_port_in),
        .level    (wave_in_level),
        .rise     (),
        .fall     ()
    );

    // Free-running prescaler; it is never reset by a start, so the first
    // period after run goes high may be up to one count clock short.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_r <= 9'h000;
        else if (pclk_en)
            pre_r <= pre_r + 9'h001;
    end

    // Count pulse selection per channel.
    always @*
    begin
        tick = 3'b000;
        // Counter zero: two divided clocks or an event edge.
        case ({mode_r[0][`ECSW_BIT_SRC_HI], mode_r[0][`ECSW_BIT_SRC_LO]})
            2'b00:   tick[0] = pclk_en & div_tick(pre_r, `ECSW_DIV0_A);
            2'b01:   tick[0] = pclk_en & div_tick(pre_r, `ECSW_DIV0_B);
            2'b10:   tick[0] = ev0_rise;
            default: tick[0] = ev0_fall;
        endcase
        // Counter one: same structure with its own dividers and pin.
        case ({mode_r[1][`ECSW_BIT_SRC_HI], mode_r[1][`ECSW_BIT_SRC_LO]})
            2'b00:   tick[1] = pclk_en & div_tick(pre_r, `ECSW_DIV1_A);
            2'b01:   tick[1] = pclk_en & div_tick(pre_r, `ECSW_DIV1_B);
            2'b10:   tick[1] = ev1_rise;
            default: tick[1] = ev1_fall;
        endcase
        // Counter two: divided main clock or subsystem clock; no pin input.
        case ({mode_r[2][`ECSW_BIT_SRC_HI], mode_r[2][`ECSW_BIT_SRC_LO]})
            2'b00:   tick[2] = pclk_en & div_tick(pre_r, `ECSW_DIV2_A);
            2'b01:   tick[2] = pclk_en & div_tick(pre_r, `ECSW_DIV2_B);
            2'b10:   tick[2] = sub_rise;
            default: tick[2] = 1'b0;
        endcase
    end

    // Run enables; the barred counter two clock code keeps it stopped.
    assign run_eff[0] = mode_r[0][`ECSW_BIT_RUN];
    assign run_eff[1] = mode_r[1][`ECSW_BIT_RUN];
    assign run_eff[2] = mode_r[2][`ECSW_BIT_RUN] &
                        ~(mode_r[2][`ECSW_BIT_SRC_HI] & mode_r[2][`ECSW_BIT_SRC_LO]);

    // The three counter channels.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : gen_ch
            ecsw_cnt u_cnt
            (
                .pclk    (pclk),
                .presetn (presetn),
                .pclk_en (pclk_en),
                .run     (run_eff[g]),
                .tick    (tick[g]),
                .cmp     (cmp_r[g]),
                .value   (value[g]),
                .match   (match[g])
            );
        end
    endgenerate

    // Square wave: low while the run bit or the output enable is clear (the barred code only holds it), inverted on each match.
    always @*
    begin
        wave_nxt = wave_r;
        if (!mode_r[2][`ECSW_BIT_RUN])
            wave_nxt = 1'b0;
        else if (!mode_r[2][`ECSW_BIT_WAVE_OE])
            wave_nxt = 1'b0;
        else if (match[2])
            wave_nxt = ~wave_r;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wave_r <= 1'b0;
        else if (pclk_en)
            wave_r <= wave_nxt;
    end

    // Shared pin: timer wave when enabled, otherwise the port latch.
    assign wave_port_out = mode_r[2][`ECSW_BIT_WAVE_OE] ? wave_r
                                                        : port_r[`ECSW_BIT_PORT_LAT];
    assign wave_port_oe  = ~port_r[`ECSW_BIT_PORT_DIR];

    // Match pulses straight out of the channels.
    assign match_irq_zero = match[0];
    assign match_irq_one  = match[1];
    assign wave_match_irq = match[2];

    // APB phases; every access completes without wait states.
    assign setup_ph = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite & hit;
    assign clr_wr   = wr_acc & (paddr == `ECSW_OFS_IRQ_CLR);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~hit;

    // Address decode and read multiplexer.
    always @*
    begin
        hit     = (paddr[1:0] == 2'b00);
        rd_data = 32'h0000_0000;
        case (paddr)
            `ECSW_OFS_MODE0:    rd_data[7:0] = mode_r[0];
            `ECSW_OFS_MODE1:    rd_data[7:0] = mode_r[1];
            `ECSW_OFS_MODE2:    rd_data[7:0] = mode_r[2];
            `ECSW_OFS_CMP0:     rd_data[7:0] = cmp_r[0];
            `ECSW_OFS_CMP1:     rd_data[7:0] = cmp_r[1];
            `ECSW_OFS_CMP2:     rd_data[7:0] = cmp_r[2];
            `ECSW_OFS_CNT0:     rd_data[7:0] = value[0];
            `ECSW_OFS_CNT1:     rd_data[7:0] = value[1];
            `ECSW_OFS_CNT2:     rd_data[7:0] = value[2];
            `ECSW_OFS_PORT:     rd_data[7:0] = port_r;
            `ECSW_OFS_IRQ_STAT: rd_data[2:0] = irq_stat_r;
            `ECSW_OFS_IRQ_CLR:  rd_data      = 32'h0000_0000;
            `ECSW_OFS_IRQ_EN:   rd_data[2:0] = irq_en_r;
            `ECSW_OFS_PIN_STAT: rd_data[3:0] = {wave_r, wave_in_level, ev1_level, ev0_level};
            default:            hit          = 1'b0;
        endcase
    end

    // Read data is captured in the setup cycle and held through access.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (pclk_en && setup_ph)
            prdata_r <= (hit && !pwrite) ? rd_data : 32'h0000_0000;
    end

    assign prdata = prdata_r;

    // Writable registers; count and status words ignore writes.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (k = 0; k < 3; k = k + 1)
            begin
                mode_r[k] <= `ECSW_MODE_RST;
                cmp_r[k]  <= `ECSW_CMP_RST;
            end
            port_r   <= `ECSW_PORT_RST;
            irq_en_r <= `ECSW_IRQ_RST;
        end
        else if (pclk_en && wr_acc)
        begin
            case (paddr)
                `ECSW_OFS_MODE0:  mode_r[0] <= pwdata[7:0] & `ECSW_MODE01_MASK;
                `ECSW_OFS_MODE1:  mode_r[1] <= pwdata[7:0] & `ECSW_MODE01_MASK;
                `ECSW_OFS_MODE2:  mode_r[2] <= pwdata[7:0] & `ECSW_MODE2_MASK;
                `ECSW_OFS_CMP0:   cmp_r[0]  <= pwdata[7:0];
                `ECSW_OFS_CMP1:   cmp_r[1]  <= pwdata[7:0];
                `ECSW_OFS_CMP2:   cmp_r[2]  <= pwdata[7:0];
                `ECSW_OFS_PORT:   port_r    <= pwdata[7:0] & `ECSW_PORT_MASK;
                `ECSW_OFS_IRQ_EN: irq_en_r  <= pwdata[2:0];
                default:          port_r    <= port_r;
            endcase
        end
    end

    // Sticky match status; a match in the clearing cycle wins.
    always @*
    begin
        irq_stat_nxt = irq_stat_r;
        if (clr_wr)
            irq_stat_nxt = irq_stat_nxt & ~pwdata[2:0];
        irq_stat_nxt = irq_stat_nxt | match;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_r <= `ECSW_IRQ_RST;
        else if (pclk_en)
            irq_stat_r <= irq_stat_nxt;
    end

    // Level interrupt while any enabled status bit is set.
    assign irq = |(irq_stat_r & irq_en_r);
endmodule

// File: tb/ecsw_pulse_src.sv
// Purpose: External pulse source, subsystem clock and wave pin load.
// Assumes: Event levels are held 8 pclk cycles, well above the sync limit.
// Notes:   The wave pin has a pull-up, so a released pin reads high.
module ecsw_pulse_src
(
    input  wire  pclk,
    output logic event_input_zero,
    output logic event_input_one,
    output logic sub_clk_in,
    input  wire  wave_port_out,
    input  wire  wave_port_oe,
    output wire  wave_port_in
);
    timeunit 1ns;
    timeprecision 1ps;
    parameter int SUB_DIV = 10;
    int sub_cnt = 0;

    // Pins start low at time zero.
    initial
    begin
        event_input_zero = 1'b0;
        event_input_one = 1'b0;
        sub_clk_in = 1'b0;
    end

    // Free-running subsystem clock of SUB_DIV pclk periods.
    always @(posedge pclk)
    begin
        sub_cnt <= (sub_cnt + 1) % SUB_DIV;
        sub_clk_in <= (sub_cnt < SUB_DIV / 2);
    end

    // Resolved pin level seen by the input buffer.
    assign wave_port_in = wave_port_oe ? wave_port_out : 1'b1;

    // Toggles one event pin k times, each level held 8 cycles.
    task automatic toggle(input int ch, input int k);
        repeat (k)
        begin
            repeat (8) @(posedge pclk);
            if (ch == 0)
                event_input_zero <= !event_input_zero;
            else
                event_input_one <= !event_input_one;
        end
    endtask
endmodule

// File: tb/ecsw_top_sva.sv
// Purpose: Port-level assertions for the three compare-match timers.
// Assumes: Register writes are mirrored from the APB port with pclk_en high.
// Notes:   Bound to ecsw_top after the module.
`include "ecsw_map.vh"
module ecsw_sva
(
    input wire        pclk,
    input wire        presetn,
    input wire        pclk_en,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    input wire        wave_port_out,
    input wire        wave_port_oe,
    input wire        match_irq_zero,
    input wire        match_irq_one,
    input wire        wave_match_irq,
    input wire        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [7:0] m_r [0:13];
    wire       bad_a = (paddr[1:0] != 2'b00) || (paddr > `ECSW_OFS_PIN_STAT);
    wire       wr_go = psel && penable && pwrite && pclk_en && !bad_a;

    // Mirrors the control registers so the rules can be tied to ports.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 14; i++)
                m_r[i] <= (i == 9) ? `ECSW_PORT_RST : 8'h00;
        end
        else if (wr_go)
            m_r[paddr[5:2]] <= pwdata[7:0];
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Steps of a stopped wave and of an enabled interrupt source.
    sequence s_wave_stopped;
        (!m_r[2][7] && m_r[2][0]) [*2];
    endsequence
    sequence s_irq_cause;
        (match_irq_zero && m_r[12][0]) || (match_irq_one && m_r[12][1]) ||
        (wave_match_irq && m_r[12][2]);
    endsequence

    chk_pulse_zero: assert property (match_irq_zero |=> !match_irq_zero)
        else $error("match zero pulse too long");
    chk_pulse_one: assert property (match_irq_one |=> !match_irq_one)
        else $error("match one pulse too long");
    chk_pulse_wave: assert property (wave_match_irq |=> !wave_match_irq)
        else $error("wave match pulse too long");
    // The wave register turns over one cycle after the match pulse shows.
    chk_wave_toggle: assert property (wave_match_irq && m_r[2][7] && m_r[2][0]
        |=> wave_port_out != $past(wave_port_out)) else $error("wave did not toggle");
    chk_wave_stop_low: assert property (s_wave_stopped |-> !wave_port_out)
        else $error("stopped wave not low");
    chk_port_mode: assert property (!m_r[2][0] |-> wave_port_out == m_r[9][1]
        && wave_port_oe == !m_r[9][0]) else $error("port pin not ordinary");
    chk_irq_raise: assert property (s_irq_cause |-> ##[1:2] irq)
        else $error("irq not raised");
    chk_irq_masked: assert property ((m_r[12][2:0] == 3'b000) [*2] |-> !irq)
        else $error("masked irq high");
    chk_stop_quiet: assert property ((!m_r[0][7]) [*2] |-> !match_irq_zero)
        else $error("stopped counter matched");
    chk_barred_code: assert property ((m_r[2][2:1] == 2'b11) [*2] |-> !wave_match_irq)
        else $error("barred clock code counted");
    chk_bad_addr: assert property (psel && penable && bad_a |-> pslverr)
        else $error("bad address not refused");
endmodule

bind ecsw_top ecsw_sva i_sva
(
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .wave_port_out(wave_port_out), .wave_port_oe(wave_port_oe),
    .match_irq_zero(match_irq_zero), .match_irq_one(match_irq_one),
    .wave_match_irq(wave_match_irq), .irq(irq)
);

// File: tb/ecsw_top_test.sv
// Purpose: Self-checking bench for the compare-match timers.
// Assumes: Zero-wait APB; event pins come from the pulse source model.
// Notes:   Divider figures are taken from the register map header.
`include "ecsw_map.vh"
module ecsw_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        err_r;
    wire  [31:0] prdata;
    wire         pready, pslverr, ev0, ev1, sub_clk, wave_in, wave_out, wave_oe;
    wire         mi0, mi1, wmi, irq;
    int          error_cnt = 0;
    int          checks = 0;
    int          cyc = 0;
    int          mc0 = 0;
    int          mc1 = 0;

    ecsw_top i_dut
    (
        .pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .event_input_zero(ev0), .event_input_one(ev1),
        .sub_clk_in(sub_clk), .wave_port_in(wave_in), .wave_port_out(wave_out),
        .wave_port_oe(wave_oe), .match_irq_zero(mi0), .match_irq_one(mi1),
        .wave_match_irq(wmi), .irq(irq)
    );
    ecsw_pulse_src i_src
    (
        .pclk(pclk), .event_input_zero(ev0), .event_input_one(ev1), .sub_clk_in(sub_clk),
        .wave_port_out(wave_out), .wave_port_oe(wave_oe), .wave_port_in(wave_in)
    );

    initial forever #2 pclk = ~pclk;

    // Counts cycles and match pulses; a hang ends the run here.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        mc0 <= mc0 + mi0;
        mc1 <= mc1 + mi1;
        if (cyc == 20000)
        begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            final_report();
        end
    end

    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer: setup, then access until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err_r = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, a, 32'h0000_0000, r);
        chk(r, exp, "read");
    endtask

    // Reset values of every readable register but the clear and pin status words, and refused addresses.
    task automatic reset_test();
        for (int i = 0; i < 13; i++)
        begin
            if (i != 11)
                rd(8'(i * 4), (i == 9) ? `ECSW_PORT_RST : 32'h0000_0000);
        end
        chk(err_r, 1'b0, "mapped error");
        chk(wave_oe, 1'b0, "pin released");
        rd(8'h38, 32'h0000_0000);
        chk(err_r, 1'b1, "unmapped error");
        rd(8'h02, 32'h0000_0000);
        chk(err_r, 1'b1, "misaligned error");
        $display("reset test done");
    endtask

    // Event counting on one pin: k toggles from low, chosen edge counted.
    task automatic ev_test(input int ch, input logic fall, input logic [7:0] cmp,
                           input int k, input logic [2:0] en);
        logic [7:0] mo;
        logic [7:0] md;
        int         e;
        int         base;
        mo = 8'(ch * 4);
        md = fall ? 8'h06 : 8'h04;
        e = fall ? k / 2 : (k + 1) / 2;
        wr(mo, 32'h0000_0000);
        wr(mo, md);
        wr(`ECSW_OFS_CMP0 + mo, cmp);
        wr(`ECSW_OFS_IRQ_EN, en);
        wr(`ECSW_OFS_IRQ_CLR, 32'h0000_0007);
        wr(mo, md | 8'h80);
        base = ch ? mc1 : mc0;
        i_src.toggle(ch, k);
        repeat (8) @(posedge pclk);
        rd(`ECSW_OFS_CNT0 + mo, e % (cmp + 1));
        chk((ch ? mc1 : mc0) - base, e / (cmp + 1), "matches");
        rd(`ECSW_OFS_IRQ_STAT, (e > cmp) ? (1 << ch) : 0);
        chk(irq, (e > cmp) && en[ch], "irq level");
        wr(`ECSW_OFS_IRQ_CLR, 1 << ch);
        rd(`ECSW_OFS_IRQ_STAT, 32'h0000_0000);
        wr(mo, md);
        rd(`ECSW_OFS_CNT0 + mo, 32'h0000_0000);
        i_src.toggle(ch, k % 2);
        $display("event test %0d done", ch);
    endtask

    // Square wave from one clock source: start level, half period, stop.
    task automatic wave_test(input logic [1:0] code, input logic [7:0] cmp, input int per);
        int n;
        wr(`ECSW_OFS_PORT, 32'h0000_0000);
        wr(`ECSW_OFS_MODE2, 32'h0000_0000);
        wr(`ECSW_OFS_MODE2, {5'b00000, code, 1'b1});
        chk(wave_out, 1'b0, "wave start");
        chk(wave_oe, 1'b1, "wave drive");
        wr(`ECSW_OFS_CMP2, cmp);
        wr(`ECSW_OFS_MODE2, {5'b10000, code, 1'b1});
        do @(posedge pclk); while (wmi !== 1'b1);
        // The wave register turns over one cycle after the match pulse.
        @(posedge pclk);
        chk(wave_out, 1'b1, "first toggle");
        n = 1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (wmi !== 1'b1);
        chk(n, (cmp + 1) * per, "half period");
        @(posedge pclk);
        chk(wave_out, 1'b0, "second toggle");
        wr(`ECSW_OFS_MODE2, {5'b00000, code, 1'b1});
        @(posedge pclk);
        chk(wave_out, 1'b0, "stopped low");
        rd(`ECSW_OFS_CNT2, 32'h0000_0000);
        wr(`ECSW_OFS_MODE2, 32'h0000_0000);
        wr(`ECSW_OFS_PORT, 32'h0000_0002);
        @(posedge pclk);
        chk(wave_out, 1'b1, "port latch");
        wr(`ECSW_OFS_PORT, `ECSW_PORT_RST);
        @(posedge pclk);
        chk(wave_oe, 1'b0, "port input");
        $display("wave test %0d done", code);
    endtask

    // The barred clock code leaves counter two stopped.
    task automatic barred_test();
        wr(`ECSW_OFS_CMP2, 32'h0000_0000);
        wr(`ECSW_OFS_MODE2, 32'h0000_0006);
        wr(`ECSW_OFS_MODE2, 32'h0000_0086);
        repeat (200) @(posedge pclk);
        rd(`ECSW_OFS_CNT2, 32'h0000_0000);
        wr(`ECSW_OFS_MODE2, 32'h0000_0000);
        $display("barred code test done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        reset_test();
        ev_test(0, 1'b0, 8'h02, 7, 3'b001);
        ev_test(1, 1'b1, 8'h00, 7, 3'b000);
        ev_test(0, 1'b1, 8'h04, 5, 3'b001);
        wave_test(2'd0, 8'h01, 1 << `ECSW_DIV2_A);
        wave_test(2'd1, 8'h00, 1 << `ECSW_DIV2_B);
        wave_test(2'd2, 8'h01, i_src.SUB_DIV);
        barred_test();
        final_report();
    end
endmodule
